// file: rtl/odpcr_pkg.sv
// Package for the optical drive packet command responder.
// Assumes a single 40 MHz clock domain shared by all users.
package odpcr_pkg;

    // ATA task-level commands.
    localparam logic [7:0] ATA_READ_SECTORS = 8'h20;
    localparam logic [7:0] ATA_IDENTIFY     = 8'hec;
    localparam logic [7:0] ATA_PACKET       = 8'ha0;
    localparam logic [7:0] ATA_STANDBY      = 8'he2;
    localparam logic [7:0] ATA_STANDBY_IMM  = 8'he0;

    // Packet operation codes.
    localparam logic [7:0] OP_TEST_READY    = 8'h00;
    localparam logic [7:0] OP_READ10        = 8'h28;
    localparam logic [7:0] OP_SEEK          = 8'h2b;
    localparam logic [7:0] OP_START_STOP    = 8'h1b;
    localparam logic [7:0] OP_LOCK_UNLOCK   = 8'h1e;
    localparam logic [7:0] OP_READ_CD       = 8'hbe;

    // Sector selection bytes for the CD read.
    localparam logic [7:0] SEL_DATA         = 8'hf8;
    localparam logic [7:0] SEL_AUDIO        = 8'hf0;

    // Packet byte positions.
    localparam int CDB_BYTES     = 12;
    localparam int CDB_SEL_BYTE  = 9;
    localparam int CDB_SS_BYTE   = 4;
    localparam int CDB_LOCK_BYTE = 4;
    localparam int SS_START_BIT  = 0;
    localparam int SS_EJECT_BIT  = 1;

    // Sense values.
    localparam logic [3:0] SK_NONE          = 4'h0;
    localparam logic [3:0] SK_NOT_READY     = 4'h2;
    localparam logic [3:0] SK_MEDIUM_ERR    = 4'h3;
    localparam logic [3:0] SK_ILLEGAL       = 4'h5;
    localparam logic [7:0] ASC_NO_MEDIUM    = 8'h3a;
    localparam logic [7:0] ASC_INCOMPAT     = 8'h30;
    localparam logic [7:0] ASCQ_INCOMPAT    = 8'h02;
    localparam logic [7:0] ASC_INVALID_OP   = 8'h20;
    localparam logic [7:0] ASC_NOT_READY    = 8'h04;

    // Packet-device signature placed in the cylinder registers.
    localparam logic [7:0] SIG_CYL_LOW      = 8'h14;
    localparam logic [7:0] SIG_CYL_HIGH     = 8'heb;

    // Drive-select bit in the device/head register.
    localparam int DRV_SEL_BIT = 4;

    // Timing.
    localparam int CLK_MHZ        = 40;
    localparam int SPIN_UP_US     = 100;
    localparam int SPIN_UP_CYC    = SPIN_UP_US * CLK_MHZ;
    localparam int SEEK_US        = 10;
    localparam int SEEK_CYC       = SEEK_US * CLK_MHZ;

    typedef struct packed {
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
    } odpcr_sense_t;

    typedef struct packed {
        logic [7:0] cyl_low;
        logic [7:0] cyl_high;
        logic [7:0] dev_head;
        logic [7:0] status;
    } odpcr_task_t;

    typedef enum logic [1:0] {
        ODPCR_SECT_NONE,
        ODPCR_SECT_DATA,
        ODPCR_SECT_AUDIO
    } odpcr_sect_t;

endpackage : odpcr_pkg

// file: rtl/odpcr_top.sv
// Command interpreter of an optical drive on the ATA packet interface.
// Assumes the ATA transport delivers one command or full packet per strobe, in
// the clk domain, and that the mechanism reports its state as plain levels.
// Summary of operation
// - Load packet signature on ATA read or identify.
// - Data read on audio track fails with incompatible-format sense.
// - Packet seek command is implemented.
// - Seek end sets seek-complete flag, drive-select bit untouched.
// - Unit-ready with tray open or no disc: sense 2, code 3A.
// - CD read with selection F8h returns data sectors.
// - CD read with selection F0h returns raw audio sectors.
// - Stop and start unit spin down and fully spin up again.
// - ATA standby spins down; next access spins up and resumes.
// - Optional software eject with medium lock and unlock.
`timescale 1ns/1ps
`default_nettype none
module odpcr_top #(
    parameter int SPIN_UP_CYC = odpcr_pkg::SPIN_UP_CYC
) (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Command strobes from the transport.
    input  wire logic                   ata_cmd_valid,
    input  wire logic [7:0]             ata_cmd,
    input  wire logic                   pkt_valid,
    input  wire logic [95:0]            pkt_cdb,
    input  wire logic [7:0]             dev_head_in,
    // Mechanism state, asynchronous levels.
    input  wire logic                   tray_open,
    input  wire logic                   disc_present,
    input  wire logic                   track_is_audio,
    input  wire logic                   audio_supported,
    // Completion and state.
    output logic                        cmd_done,
    output logic                        cmd_error,
    output logic                        busy,
    output odpcr_pkg::odpcr_task_t      task_regs,
    output odpcr_pkg::odpcr_sense_t     sense,
    output odpcr_pkg::odpcr_sect_t      sect_type,
    output logic                        xfer_start,
    output logic                        spindle_on,
    output logic                        eject_pulse,
    output logic                        medium_locked,
    output logic                        seek_complete_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Synchronise mechanism levels.

    logic [3:0] mech_meta_ff;
    logic [3:0] mech_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mech_meta_ff <= 4'h0;
            mech_ff      <= 4'h0;
        end else begin
            mech_meta_ff <= {audio_supported, track_is_audio, disc_present, tray_open};
            mech_ff      <= mech_meta_ff;
        end
    end

    logic s_tray_open;
    logic s_disc;
    logic s_audio_trk;
    logic s_audio_ok;
    assign s_tray_open = mech_ff[0];
    assign s_disc      = mech_ff[1];
    assign s_audio_trk = mech_ff[2];
    assign s_audio_ok  = mech_ff[3];

    function automatic logic [7:0] cdb_byte(input logic [95:0] cdb, input int idx);
        cdb_byte = cdb[95 - idx*8 -: 8];
    endfunction : cdb_byte

    function automatic odpcr_pkg::odpcr_sense_t mk_sense(input logic [3:0] k, input logic [7:0] a,
                                                         input logic [7:0] q);
        mk_sense = '{key: k, asc: a, ascq: q};
    endfunction : mk_sense

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer.

    typedef enum logic [1:0] {ST_IDLE, ST_SPIN, ST_SEEK} odpcr_state_t;

    odpcr_state_t state_ff;
    logic [31:0]  timer_ff;
    logic         after_spin_seek_ff;
    logic         pending_seek_ff;

    logic medium_ok;
    assign medium_ok = s_disc && !s_tray_open;

    // Decoded packet fields.
    logic [7:0] op;
    logic [7:0] sel;
    logic [7:0] ss;
    logic [7:0] lock_byte;
    logic       is_zero_cdb;
    assign op          = cdb_byte(pkt_cdb, 0);
    assign sel         = cdb_byte(pkt_cdb, odpcr_pkg::CDB_SEL_BYTE);
    assign ss          = cdb_byte(pkt_cdb, odpcr_pkg::CDB_SS_BYTE);
    assign lock_byte   = cdb_byte(pkt_cdb, odpcr_pkg::CDB_LOCK_BYTE);
    assign is_zero_cdb = (pkt_cdb == 96'h0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff           <= ST_IDLE;
            timer_ff           <= 32'h0;
            after_spin_seek_ff <= 1'b0;
            pending_seek_ff    <= 1'b0;
            cmd_done           <= 1'b0;
            cmd_error          <= 1'b0;
            busy               <= 1'b0;
            sense              <= '0;
            sect_type          <= odpcr_pkg::ODPCR_SECT_NONE;
            xfer_start         <= 1'b0;
            spindle_on         <= 1'b0;
            eject_pulse        <= 1'b0;
            medium_locked      <= 1'b0;
            seek_complete_flag <= 1'b0;
            task_regs          <= '0;
        end else begin
            cmd_done    <= 1'b0;
            cmd_error   <= 1'b0;
            xfer_start  <= 1'b0;
            eject_pulse <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (ata_cmd_valid) begin
                        cmd_done <= 1'b1;
                        if (ata_cmd == odpcr_pkg::ATA_READ_SECTORS || ata_cmd == odpcr_pkg::ATA_IDENTIFY) begin
                            task_regs.cyl_low  <= odpcr_pkg::SIG_CYL_LOW;
                            task_regs.cyl_high <= odpcr_pkg::SIG_CYL_HIGH;
                            task_regs.dev_head <= dev_head_in;
                            cmd_error          <= 1'b1;
                        end else if (ata_cmd == odpcr_pkg::ATA_STANDBY || ata_cmd == odpcr_pkg::ATA_STANDBY_IMM) begin
                            spindle_on <= 1'b0;
                            sense      <= '0;
                        end else if (ata_cmd != odpcr_pkg::ATA_PACKET) begin
                            cmd_error <= 1'b1;
                        end
                    end else if (pkt_valid) begin
                        task_regs.dev_head <= dev_head_in;
                        if (op == odpcr_pkg::OP_TEST_READY && is_zero_cdb) begin
                            cmd_done <= 1'b1;
                            if (!medium_ok) begin
                                cmd_error <= 1'b1;
                                sense <= mk_sense(odpcr_pkg::SK_NOT_READY, odpcr_pkg::ASC_NO_MEDIUM, 8'h00);
                            end else begin
                                sense <= '0;
                            end
                        end else if (op == odpcr_pkg::OP_START_STOP) begin
                            cmd_done <= !ss[odpcr_pkg::SS_START_BIT];
                            if (ss[odpcr_pkg::SS_EJECT_BIT] && !ss[odpcr_pkg::SS_START_BIT]) begin
                                if (medium_locked) begin
                                    cmd_error <= 1'b1;
                                    sense <= mk_sense(odpcr_pkg::SK_ILLEGAL, 8'h53, 8'h02);
                                end else begin
                                    eject_pulse <= 1'b1;
                                    sense       <= '0;
                                end
                                spindle_on <= 1'b0;
                            end else if (ss[odpcr_pkg::SS_START_BIT]) begin
                                spindle_on         <= 1'b1;
                                busy               <= 1'b1;
                                timer_ff           <= 32'(SPIN_UP_CYC);
                                after_spin_seek_ff <= 1'b0;
                                state_ff           <= ST_SPIN;
                            end else begin
                                spindle_on <= 1'b0;
                                sense      <= '0;
                            end
                        end else if (op == odpcr_pkg::OP_LOCK_UNLOCK) begin
                            medium_locked <= lock_byte[0];
                            cmd_done      <= 1'b1;
                            sense         <= '0;
                        end else if (!medium_ok && (op == odpcr_pkg::OP_SEEK || op == odpcr_pkg::OP_READ10
                                     || op == odpcr_pkg::OP_READ_CD)) begin
                            cmd_done  <= 1'b1;
                            cmd_error <= 1'b1;
                            sense <= mk_sense(odpcr_pkg::SK_NOT_READY, odpcr_pkg::ASC_NO_MEDIUM, 8'h00);
                        end else if (op == odpcr_pkg::OP_READ10 && s_audio_trk) begin
                            cmd_done  <= 1'b1;
                            cmd_error <= 1'b1;
                            sense <= mk_sense(odpcr_pkg::SK_MEDIUM_ERR, odpcr_pkg::ASC_INCOMPAT,
                                              odpcr_pkg::ASCQ_INCOMPAT);
                        end else if (op == odpcr_pkg::OP_SEEK || op == odpcr_pkg::OP_READ10
                                     || (op == odpcr_pkg::OP_READ_CD && (sel == odpcr_pkg::SEL_DATA
                                     || (sel == odpcr_pkg::SEL_AUDIO && s_audio_ok)))) begin
                            busy               <= 1'b1;
                            seek_complete_flag <= 1'b0;
                            pending_seek_ff    <= (op == odpcr_pkg::OP_SEEK);
                            if (op == odpcr_pkg::OP_READ_CD && sel == odpcr_pkg::SEL_AUDIO) begin
                                sect_type <= odpcr_pkg::ODPCR_SECT_AUDIO;
                            end else if (op != odpcr_pkg::OP_SEEK) begin
                                sect_type <= odpcr_pkg::ODPCR_SECT_DATA;
                            end
                            if (!spindle_on) begin
                                spindle_on         <= 1'b1;
                                timer_ff           <= 32'(SPIN_UP_CYC);
                                after_spin_seek_ff <= 1'b1;
                                state_ff           <= ST_SPIN;
                            end else begin
                                timer_ff <= 32'(odpcr_pkg::SEEK_CYC);
                                state_ff <= ST_SEEK;
                            end
                        end else begin
                            cmd_done  <= 1'b1;
                            cmd_error <= 1'b1;
                            sense <= mk_sense(odpcr_pkg::SK_ILLEGAL, odpcr_pkg::ASC_INVALID_OP, 8'h00);
                        end
                    end
                end
                ST_SPIN: begin
                    if (timer_ff > 32'h1) begin
                        timer_ff <= timer_ff - 32'h1;
                    end else if (after_spin_seek_ff) begin
                        timer_ff <= 32'(odpcr_pkg::SEEK_CYC);
                        state_ff <= ST_SEEK;
                    end else begin
                        busy     <= 1'b0;
                        cmd_done <= 1'b1;
                        sense    <= '0;
                        state_ff <= ST_IDLE;
                    end
                end
                ST_SEEK: begin
                    if (timer_ff > 32'h1) begin
                        timer_ff <= timer_ff - 32'h1;
                    end else begin
                        // Drive-select is left as latched; only the status flag moves.
                        busy               <= 1'b0;
                        cmd_done           <= 1'b1;
                        seek_complete_flag <= 1'b1;
                        xfer_start         <= !pending_seek_ff;
                        sense              <= '0;
                        state_ff           <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
            task_regs.status <= {busy, 1'b1, 1'b0, seek_complete_flag, 3'h0, cmd_error};
        end
    end

endmodule : odpcr_top
`default_nettype wire

// file: sim/odpcr_host_model.sv
// Host controller model: issues one ATA command or packet at a time.
// Assumes the bench calls its tasks and the responder answers with cmd_done.
`timescale 1ns/1ps
`default_nettype none
module odpcr_host_model (
    // Clock and answers.
    input  wire logic        clk,
    input  wire logic        cmd_done,
    input  wire logic        cmd_error,
    input  wire logic        xfer_start,
    input  wire logic        eject_pulse,
    // Command strobes.
    output var logic         ata_cmd_valid,
    output var logic [7:0]   ata_cmd,
    output var logic         pkt_valid,
    output var logic [95:0]  pkt_cdb,
    output var logic [7:0]   dev_head_in
);
    int   n;
    logic err;
    logic saw_x;
    logic saw_e;
    initial begin
        ata_cmd_valid = 1'b0;
        pkt_valid = 1'b0;
        ata_cmd = 8'h00;
        pkt_cdb = 96'h0;
        dev_head_in = 8'h00;
    end
    // Waits for completion, counting cycles from the accepting edge.
    task automatic wait_done(input int lim);
        n = 0;
        // Pulses launched on the accepting edge stand here already.
        saw_x = xfer_start;
        saw_e = eject_pulse;
        while (cmd_done !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
            saw_x = saw_x | xfer_start;
            saw_e = saw_e | eject_pulse;
        end
        // A command that never finished leaves an unknown, which fails any compare.
        err = (cmd_done === 1'b1) ? cmd_error : 1'bx;
    endtask : wait_done
    // Released lines carry inverted data so a stale command is never mistaken for a held one.
    task automatic send_pkt(input logic [95:0] cdb, input logic [7:0] dh, input int lim);
        @(negedge clk);
        pkt_cdb = cdb;
        dev_head_in = dh;
        pkt_valid = 1'b1;
        @(negedge clk);
        pkt_valid = 1'b0;
        pkt_cdb = ~cdb;
        wait_done(lim);
    endtask : send_pkt
    task automatic send_ata(input logic [7:0] cmd, input int lim);
        @(negedge clk);
        ata_cmd = cmd;
        ata_cmd_valid = 1'b1;
        @(negedge clk);
        ata_cmd_valid = 1'b0;
        ata_cmd = ~cmd;
        wait_done(lim);
    endtask : send_ata
endmodule : odpcr_host_model
`default_nettype wire

// file: sim/odpcr_properties.sv
// Port-level assertions for the packet command responder.
// Assumes one clock, asynchronous active-high reset and one command at a time.
`timescale 1ns/1ps
`default_nettype none
module odpcr_properties #(
    parameter int SPIN_UP_CYC = 4
) (
    // Clock and reset.
    input wire logic                   clk,
    input wire logic                   rst,
    // Requests and mechanism.
    input wire logic                   ata_cmd_valid,
    input wire logic [7:0]             ata_cmd,
    input wire logic                   pkt_valid,
    input wire logic [95:0]            pkt_cdb,
    input wire logic                   tray_open,
    input wire logic                   disc_present,
    // Answers.
    input wire logic                   busy,
    input wire logic                   cmd_done,
    input wire logic                   cmd_error,
    input wire odpcr_pkg::odpcr_task_t task_regs,
    input wire odpcr_pkg::odpcr_sense_t sense,
    input wire logic                   spindle_on,
    input wire logic                   seek_complete_flag
);
    // A seek waits the full positioning time; the property needs the spindle on, so no spin-up adds to this bound.
    localparam int SEEK_MAX = 1000;
    wire logic acc = (ata_cmd_valid || pkt_valid) && !busy;
    wire logic pk = pkt_valid && !ata_cmd_valid && !busy;
    wire logic no_med = tray_open || !disc_present;
    wire logic [7:0] op = pkt_cdb[95:88];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    property p_sig;
        ata_cmd_valid && !busy && (ata_cmd == odpcr_pkg::ATA_IDENTIFY || ata_cmd == odpcr_pkg::ATA_READ_SECTORS)
            |-> ##[1:2] task_regs.cyl_low == odpcr_pkg::SIG_CYL_LOW && task_regs.cyl_high == odpcr_pkg::SIG_CYL_HIGH;
    endproperty
    a_sig: assert property (p_sig)
        else $error("signature not loaded");
    property p_tur;
        pk && pkt_cdb == 96'h0 && no_med && $past(no_med) && $past(no_med, 2) && $past(no_med, 3)
            |=> cmd_done && cmd_error && sense.key == odpcr_pkg::SK_NOT_READY && sense.asc == odpcr_pkg::ASC_NO_MEDIUM;
    endproperty
    a_tur: assert property (p_tur)
        else $error("unit-ready without medium not refused");
    property p_seek;
        pk && op == odpcr_pkg::OP_SEEK && spindle_on && !no_med
            |=> !seek_complete_flag && busy ##[1:SEEK_MAX] cmd_done && seek_complete_flag;
    endproperty
    a_seek: assert property (p_seek)
        else $error("seek did not complete with flag");
    property p_dsel;
        $changed(task_regs.dev_head) |-> $past(acc) || $past(acc, 2);
    endproperty
    a_dsel: assert property (p_dsel)
        else $error("device/head changed without a command");
    property p_sense;
        $changed(sense) |-> cmd_done;
    endproperty
    a_sense: assert property (p_sense)
        else $error("sense changed outside completion");
    property p_clear;
        cmd_done && !cmd_error |-> sense == 20'h0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("sense not cleared on success");
    property p_stop;
        pk && op == odpcr_pkg::OP_START_STOP && pkt_cdb[57:56] == 2'b00 |-> ##[1:2] !spindle_on;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop unit left spindle on");
    property p_standby;
        ata_cmd_valid && !busy && (ata_cmd == odpcr_pkg::ATA_STANDBY || ata_cmd == odpcr_pkg::ATA_STANDBY_IMM)
            |-> ##[1:2] !spindle_on;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby left spindle on");
endmodule : odpcr_properties
bind odpcr_top odpcr_properties #(.SPIN_UP_CYC(SPIN_UP_CYC)) i_props (.clk(clk), .rst(rst),
    .ata_cmd_valid(ata_cmd_valid), .ata_cmd(ata_cmd), .pkt_valid(pkt_valid), .pkt_cdb(pkt_cdb),
    .tray_open(tray_open), .disc_present(disc_present), .busy(busy), .cmd_done(cmd_done),
    .cmd_error(cmd_error), .task_regs(task_regs), .sense(sense), .spindle_on(spindle_on),
    .seek_complete_flag(seek_complete_flag));
`default_nettype wire

// file: sim/odpcr_test.sv
// Self-checking bench for the packet command responder.
// Assumes a shortened spin-up count; the host model drives all command strobes.
`timescale 1ns/1ps
`default_nettype none
module odpcr_test;
    localparam int SPIN = 4;
    localparam int LIM = 600;
    logic clk;
    logic rst = 1'b1;
    logic tray_open = 1'b0;
    logic disc_present = 1'b0;
    logic track_is_audio = 1'b0;
    logic audio_supported = 1'b1;
    logic ata_cmd_valid, pkt_valid, cmd_done, cmd_error, busy, xfer_start;
    logic spindle_on, eject_pulse, medium_locked, seek_complete_flag;
    logic [7:0] ata_cmd, dev_head_in;
    logic [95:0] pkt_cdb;
    odpcr_pkg::odpcr_task_t task_regs;
    odpcr_pkg::odpcr_sense_t sense;
    odpcr_pkg::odpcr_sect_t sect_type;
    int error_cnt = 0;
    int cmp_count = 0;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    odpcr_top #(.SPIN_UP_CYC(SPIN)) i_dut (.clk(clk), .rst(rst), .ata_cmd_valid(ata_cmd_valid),
        .ata_cmd(ata_cmd), .pkt_valid(pkt_valid), .pkt_cdb(pkt_cdb), .dev_head_in(dev_head_in),
        .tray_open(tray_open), .disc_present(disc_present), .track_is_audio(track_is_audio),
        .audio_supported(audio_supported), .cmd_done(cmd_done), .cmd_error(cmd_error), .busy(busy),
        .task_regs(task_regs), .sense(sense), .sect_type(sect_type), .xfer_start(xfer_start),
        .spindle_on(spindle_on), .eject_pulse(eject_pulse), .medium_locked(medium_locked),
        .seek_complete_flag(seek_complete_flag));
    odpcr_host_model i_host (.clk(clk), .cmd_done(cmd_done), .cmd_error(cmd_error),
        .xfer_start(xfer_start), .eject_pulse(eject_pulse), .ata_cmd_valid(ata_cmd_valid),
        .ata_cmd(ata_cmd), .pkt_valid(pkt_valid), .pkt_cdb(pkt_cdb), .dev_head_in(dev_head_in));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic [95:0] cdb(input logic [7:0] op, input logic [7:0] b4, input logic [7:0] b9);
        return {op, 24'h0, b4, 32'h0, b9, 16'h0};
    endfunction : cdb
    // Mechanism levels pass a two-stage synchroniser, so allow three cycles to settle.
    task automatic mech(input logic to, input logic dp, input logic ta);
        @(negedge clk);
        tray_open = to;
        disc_present = dp;
        track_is_audio = ta;
        repeat (3) @(negedge clk);
    endtask : mech
    task automatic pkt(input logic [7:0] op, input logic [7:0] b4, input logic [7:0] b9);
        i_host.send_pkt(cdb(op, b4, b9), 8'h00, LIM);
    endtask : pkt
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_sig;
        i_host.send_ata(odpcr_pkg::ATA_IDENTIFY, 10);
        chk("sig", {odpcr_pkg::SIG_CYL_LOW, odpcr_pkg::SIG_CYL_HIGH}, {task_regs.cyl_low, task_regs.cyl_high});
        chk("abort", 1, i_host.err);
        i_host.send_ata(odpcr_pkg::ATA_READ_SECTORS, 10);
        chk("sig_rd", {odpcr_pkg::SIG_CYL_LOW, odpcr_pkg::SIG_CYL_HIGH}, {task_regs.cyl_low, task_regs.cyl_high});
    endtask : t_sig
    task automatic t_media;
        for (int i = 0; i < 2; i++) begin
            mech(i == 0, 1'b0, 1'b0);
            i_host.send_pkt(96'h0, 8'h00, 10);
            chk("tur_err", 1, i_host.err);
            chk("tur_sense", {odpcr_pkg::SK_NOT_READY, odpcr_pkg::ASC_NO_MEDIUM, 8'h00}, sense);
        end
        mech(1'b0, 1'b1, 1'b0);
        chk("held", {odpcr_pkg::SK_NOT_READY, odpcr_pkg::ASC_NO_MEDIUM, 8'h00}, sense);
        pkt(odpcr_pkg::OP_START_STOP, 8'h01, 8'h00);
        chk("spin_n", SPIN, i_host.n);
        chk("spin_on", 1, spindle_on);
        chk("cleared", 0, sense);
        i_host.send_pkt(96'h0, 8'h00, 10);
        chk("tur_ok", 0, i_host.err);
    endtask : t_media
    task automatic t_seek;
        i_host.send_pkt(cdb(odpcr_pkg::OP_SEEK, 8'h00, 8'h00), 8'h10, LIM);
        chk("seek_n", odpcr_pkg::SEEK_CYC, i_host.n);
        chk("seek_flag", 1, seek_complete_flag);
        chk("drv_sel", 1, task_regs.dev_head[odpcr_pkg::DRV_SEL_BIT]);
        // The status copy trails the flag by one cycle.
        @(negedge clk);
        chk("status_flag", 1, task_regs.status[4]);
    endtask : t_seek
    task automatic t_read;
        mech(1'b0, 1'b1, 1'b1);
        pkt(odpcr_pkg::OP_READ10, 8'h00, 8'h00);
        chk("rd_audio", {odpcr_pkg::SK_MEDIUM_ERR, odpcr_pkg::ASC_INCOMPAT, odpcr_pkg::ASCQ_INCOMPAT}, sense);
        pkt(odpcr_pkg::OP_READ_CD, 8'h00, odpcr_pkg::SEL_AUDIO);
        chk("cd_audio", {1'b0, 1'b1, odpcr_pkg::ODPCR_SECT_AUDIO}, {i_host.err, i_host.saw_x, sect_type});
        mech(1'b0, 1'b1, 1'b0);
        pkt(odpcr_pkg::OP_READ_CD, 8'h00, odpcr_pkg::SEL_DATA);
        chk("cd_data", {1'b0, 1'b1, odpcr_pkg::ODPCR_SECT_DATA}, {i_host.err, i_host.saw_x, sect_type});
    endtask : t_read
    task automatic t_power;
        pkt(odpcr_pkg::OP_START_STOP, 8'h00, 8'h00);
        chk("stop", 0, spindle_on);
        pkt(odpcr_pkg::OP_START_STOP, 8'h01, 8'h00);
        chk("restart", {1'b1, 8'(SPIN)}, {spindle_on, i_host.n[7:0]});
        i_host.send_ata(odpcr_pkg::ATA_STANDBY, 10);
        chk("standby", 0, spindle_on);
        pkt(odpcr_pkg::OP_READ_CD, 8'h00, odpcr_pkg::SEL_DATA);
        chk("resume", {1'b0, 1'b1}, {i_host.err, spindle_on});
        chk("resume_n", SPIN + odpcr_pkg::SEEK_CYC, i_host.n);
    endtask : t_power
    task automatic t_eject;
        pkt(odpcr_pkg::OP_LOCK_UNLOCK, 8'h01, 8'h00);
        chk("lock", 1, medium_locked);
        pkt(odpcr_pkg::OP_START_STOP, 8'h02, 8'h00);
        chk("ej_locked", {1'b1, 1'b0}, {i_host.err, i_host.saw_e});
        pkt(odpcr_pkg::OP_LOCK_UNLOCK, 8'h00, 8'h00);
        chk("unlock", 0, medium_locked);
        pkt(odpcr_pkg::OP_START_STOP, 8'h02, 8'h00);
        chk("ej_free", {1'b0, 1'b1}, {i_host.err, i_host.saw_e});
    endtask : t_eject
    task automatic conclude;
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_sig();
        t_media();
        t_seek();
        t_read();
        t_power();
        t_eject();
        conclude();
    end
endmodule : odpcr_test
`default_nettype wire
